/* File: vdc_controller.v */
// host-side strobe sequencer for a dual-port video dram port
// Behaviour
// - controller holds special-function select at both strobe falls.
// - read, write and rmw may mix freely within one open page.
// - write-strobe low at row fall selects per-bit mask on data pins.
// - block writes carry column mask on data pins at column time.
// - load-mask cycle: select high at row, low at column.
`timescale 1ns/1ps
`include "vdc_defs.vh"
module vdc_controller (
   input  wire        clk,
   input  wire        nrst,
   input  wire [3:0]  awaddr,
   input  wire        awvalid,
   output wire        awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output wire        wready,
   output wire [1:0]  bresp,
   output wire        bvalid,
   input  wire        bready,
   input  wire [3:0]  araddr,
   input  wire        arvalid,
   output wire        arready,
   output wire [31:0] rdata,
   output wire [1:0]  rresp,
   output wire        rvalid,
   input  wire        rready,
   output reg         rowStrobeN,
   output reg         colStrobeN,
   output reg  [1:0]  byteWriteStrobeN,
   output reg         transferOutputEnableN,
   output reg         specialFunctionSelect,
   output reg  [8:0]  addressIn,
   output reg  [15:0] dataOut,
   output reg         dataOe,
   input  wire [15:0] dataIn
);
   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   localparam ST_IDLE  = 3'h0;
   localparam ST_ROW   = 3'h1;
   localparam ST_COL   = 3'h2;
   localparam ST_WRITE = 3'h3;
   localparam ST_COLHI = 3'h4;
   localparam ST_ROWHI = 3'h5;

   wire [31:0] ctrlWord;
   wire [31:0] addrWord;
   wire [31:0] dataWord;
   wire        goPulse;
   wire [31:0] statWord;

   reg [2:0]              state_reg;
   reg [2:0]              state_next;
   reg [`VDC_CNT_W-1:0]   cnt_reg;
   reg                    pageOpen_reg;
   reg [8:0]              openRow_reg;
   reg [15:0]             readData_reg;
   reg                    busy_reg;
   reg                    start_reg;
   reg                    reopen_reg;
   reg [1:0]              op;
   reg                    phaseDone;

   wire [1:0] opSel    = ctrlWord[`VDC_CT_OP_HI:`VDC_CT_OP_LO];
   wire [1:0] byteEn   = {ctrlWord[`VDC_CT_BE_HI], ctrlWord[`VDC_CT_BE_LO]};
   wire [8:0] rowAddr  = addrWord[`VDC_AD_ROW_HI:`VDC_AD_ROW_LO];
   wire [8:0] colAddr  = addrWord[`VDC_AD_COL_HI:`VDC_AD_COL_LO];
   wire [15:0] wrMask  = ctrlWord[`VDC_CT_MSK_HI:`VDC_CT_MSK_LO];

   vdc_axi_slave uSlave (
      .clk      (clk),
      .nrst     (nrst),
      .awaddr   (awaddr),
      .awvalid  (awvalid),
      .awready  (awready),
      .wdata    (wdata),
      .wstrb    (wstrb),
      .wvalid   (wvalid),
      .wready   (wready),
      .bresp    (bresp),
      .bvalid   (bvalid),
      .bready   (bready),
      .araddr   (araddr),
      .arvalid  (arvalid),
      .arready  (arready),
      .rdata    (rdata),
      .rresp    (rresp),
      .rvalid   (rvalid),
      .rready   (rready),
      .ctrlWord (ctrlWord),
      .addrWord (addrWord),
      .dataWord (dataWord),
      .goPulse  (goPulse),
      .statWord (statWord)
   );

   assign statWord = {readData_reg, 6'h0, openRow_reg[7:0],
                      pageOpen_reg, busy_reg};

   // write mode is set at row fall: mask enable on write strobes
   function rowSelectMask;
      input masked;
      input isWrite;
      begin
         rowSelectMask = masked && isWrite;
      end
   endfunction

   // load-mask and read cycles keep the write strobes high at row
   wire maskSel = rowSelectMask(ctrlWord[`VDC_CT_MASKED],
                                op == `VDC_OP_WRITE || op == `VDC_OP_RMW);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always @* begin
      op = opSel;
      phaseDone = (cnt_reg == (`VDC_PHASE_CYC - 1));
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start_reg) begin
               // reuse open page for any cycle type except load-mask
               if (pageOpen_reg && rowAddr == openRow_reg &&
                   op != `VDC_OP_LDMASK)
                  state_next = ST_COL;
               else if (pageOpen_reg)
                  state_next = ST_ROWHI;
               else
                  state_next = ST_ROW;
            end
         end
         ST_ROW:   if (phaseDone) state_next = ST_COL;
         ST_COL: begin
            if (phaseDone)
               state_next = (op == `VDC_OP_READ) ? ST_COLHI : ST_WRITE;
         end
         ST_WRITE: if (phaseDone) state_next = ST_COLHI;
         ST_COLHI: begin
            if (phaseDone)
               state_next = (ctrlWord[`VDC_CT_KEEPROW] &&
                             op != `VDC_OP_LDMASK) ? ST_IDLE : ST_ROWHI;
         end
         ST_ROWHI: if (phaseDone) state_next = reopen_reg ? ST_ROW : ST_IDLE;
         default:  state_next = ST_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // sequencer and pin drive
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         cnt_reg <= {`VDC_CNT_W{1'b0}};
         pageOpen_reg <= 1'b0;
         openRow_reg <= 9'h000;
         readData_reg <= 16'h0000;
         busy_reg <= 1'b0;
         start_reg <= 1'b0;
         reopen_reg <= 1'b0;
         rowStrobeN <= 1'b1;
         colStrobeN <= 1'b1;
         byteWriteStrobeN <= 2'h3;
         transferOutputEnableN <= 1'b1;
         specialFunctionSelect <= 1'b0;
         addressIn <= 9'h000;
         dataOut <= 16'h0000;
         dataOe <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= (state_next != state_reg) ? {`VDC_CNT_W{1'b0}}
                    : cnt_reg + 1'b1;
         // start a clock after go, once the control word has landed
         start_reg <= goPulse && !busy_reg;
         if (goPulse && !busy_reg)
            busy_reg <= 1'b1;
         case (state_next)
            ST_ROW: if (state_reg != ST_ROW) begin
               // row fall: select and write strobes set the mode
               rowStrobeN <= 1'b0;
               addressIn <= rowAddr;
               openRow_reg <= rowAddr;
               pageOpen_reg <= 1'b1;
               specialFunctionSelect <= (op == `VDC_OP_LDMASK);
               transferOutputEnableN <= 1'b1;
               byteWriteStrobeN <= maskSel ? 2'h0 : 2'h3;
               // mask on data pins; ignored in persistent mode
               dataOut <= wrMask;
               dataOe <= !maskSel;
            end
            ST_COL: if (state_reg != ST_COL) begin
               byteWriteStrobeN <= 2'h3;
               colStrobeN <= 1'b0;
               // full column address driven, block writes included
               addressIn <= colAddr;
               // block or load-mask chosen at column fall
               specialFunctionSelect <= ctrlWord[`VDC_CT_BLOCK] &&
                                        op == `VDC_OP_WRITE;
               transferOutputEnableN <= !(op == `VDC_OP_READ ||
                                          op == `VDC_OP_RMW);
               dataOe <= 1'b1;
            end
            ST_WRITE: if (state_reg != ST_WRITE) begin
               // data or column mask driven at the same edge as write fall
               transferOutputEnableN <= 1'b1;
               dataOut <= dataWord[15:0];
               dataOe <= 1'b0;
               byteWriteStrobeN <= ~byteEn;
               if (op == `VDC_OP_RMW)
                  readData_reg <= dataIn;
            end
            ST_COLHI: if (state_reg != ST_COLHI) begin
               // sample read data before releasing column
               if (op == `VDC_OP_READ)
                  readData_reg <= dataIn;
               colStrobeN <= 1'b1;
               byteWriteStrobeN <= 2'h3;
               transferOutputEnableN <= 1'b1;
               dataOe <= 1'b1;
            end
            ST_ROWHI: if (state_reg != ST_ROWHI) begin
               // reopen only when leaving idle for a new row
               reopen_reg <= (state_reg == ST_IDLE);
               rowStrobeN <= 1'b1;
               colStrobeN <= 1'b1;
               pageOpen_reg <= 1'b0;
               dataOe <= 1'b1;
            end
            ST_IDLE: if (state_reg != ST_IDLE) begin
               busy_reg <= 1'b0;
               specialFunctionSelect <= 1'b0;
            end
            default: busy_reg <= busy_reg;
         endcase
      end
   end
endmodule

/* File: vdc_defs.vh */
// constants for the video dram port controller
`ifndef VDC_DEFS_VH
`define VDC_DEFS_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define VDC_OFS_CTRL    4'h0
`define VDC_OFS_ADDR    4'h4
`define VDC_OFS_DATA    4'h8
`define VDC_OFS_STAT    4'hC
// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define VDC_CT_GO       0
`define VDC_CT_OP_LO    1
`define VDC_CT_OP_HI    2
`define VDC_CT_MASKED   3
`define VDC_CT_BLOCK    4
`define VDC_CT_KEEPROW  5
`define VDC_CT_EDO      6
`define VDC_CT_BE_LO    7
`define VDC_CT_BE_HI    8
`define VDC_CT_MSK_LO   16
`define VDC_CT_MSK_HI   31
// ---------------------------------------------------------------
// address register fields
// ---------------------------------------------------------------
`define VDC_AD_COL_HI   8
`define VDC_AD_COL_LO   0
`define VDC_AD_ROW_HI   25
`define VDC_AD_ROW_LO   17
// ---------------------------------------------------------------
// operations
// ---------------------------------------------------------------
`define VDC_OP_READ     2'h0
`define VDC_OP_WRITE    2'h1
`define VDC_OP_RMW      2'h2
`define VDC_OP_LDMASK   2'h3
// ---------------------------------------------------------------
// timing: every strobe phase lasts this many clocks (40 ns each)
// ---------------------------------------------------------------
`define VDC_PHASE_NS    60
`define VDC_CLK_NS      40
`define VDC_PHASE_CYC   ((`VDC_PHASE_NS + `VDC_CLK_NS - 1) / `VDC_CLK_NS)
`define VDC_CNT_W       3
// ---------------------------------------------------------------
// axi response codes and widths
// ---------------------------------------------------------------
`define VDC_RESP_OKAY   2'h0
`define VDC_RESP_SLVERR 2'h2
`define VDC_DW          16
`define VDC_AW          9
`endif

/* File: vdc_axi_slave.v */
// axi4-lite register slave for the video dram port controller
`timescale 1ns/1ps
`include "vdc_defs.vh"
module vdc_axi_slave (
   input  wire        clk,
   input  wire        nrst,
   input  wire [3:0]  awaddr,
   input  wire        awvalid,
   output wire        awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output wire        wready,
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   input  wire [3:0]  araddr,
   input  wire        arvalid,
   output wire        arready,
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   output reg  [31:0] ctrlWord,
   output reg  [31:0] addrWord,
   output reg  [31:0] dataWord,
   output wire        goPulse,
   input  wire [31:0] statWord
);
   reg        awHeld;
   reg [3:0]  awAddrHeld;
   reg        wHeld;
   reg [31:0] wDataHeld;
   reg [3:0]  wStrbHeld;
   wire       doWrite;

   // byte-lane merge
   function [31:0] mergeLanes;
      input [31:0] oldV;
      input [31:0] newV;
      input [3:0]  strb;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            mergeLanes[i*8 +: 8] = strb[i] ? newV[i*8 +: 8]
                                           : oldV[i*8 +: 8];
         end
      end
   endfunction

   assign awready = !awHeld && !bvalid;
   assign wready  = !wHeld && !bvalid;
   assign arready = !rvalid;
   assign doWrite = awHeld && wHeld && !bvalid;
   assign goPulse = doWrite && (awAddrHeld == `VDC_OFS_CTRL) &&
                    wStrbHeld[0] && wDataHeld[`VDC_CT_GO];

   // ---------------------------------------------------------------
   // write channel
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrHeld <= 4'h0;
         wDataHeld <= 32'h0;
         wStrbHeld <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `VDC_RESP_OKAY;
         ctrlWord <= 32'h0;
         addrWord <= 32'h0;
         dataWord <= 32'h0;
      end else begin
         if (awvalid && awready) begin
            awHeld <= 1'b1;
            awAddrHeld <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld <= 1'b1;
            wDataHeld <= wdata;
            wStrbHeld <= wstrb;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            bvalid <= 1'b1;
            bresp <= `VDC_RESP_OKAY;
            case (awAddrHeld)
               `VDC_OFS_CTRL: ctrlWord <= mergeLanes(ctrlWord,
                                 wDataHeld & ~32'h1, wStrbHeld);
               `VDC_OFS_ADDR: addrWord <= mergeLanes(addrWord,
                                 wDataHeld, wStrbHeld);
               `VDC_OFS_DATA: dataWord <= mergeLanes(dataWord,
                                 wDataHeld, wStrbHeld);
               `VDC_OFS_STAT: bresp <= `VDC_RESP_OKAY;
               default:       bresp <= `VDC_RESP_SLVERR;
            endcase
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= `VDC_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp <= `VDC_RESP_OKAY;
         case (araddr)
            `VDC_OFS_CTRL: rdata <= ctrlWord;
            `VDC_OFS_ADDR: rdata <= addrWord;
            `VDC_OFS_DATA: rdata <= dataWord;
            `VDC_OFS_STAT: rdata <= statWord;
            default: begin
               rdata <= 32'h0;
               rresp <= `VDC_RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule

/* File: vdc_controller_asserts.sv */
// assertions on the strobe pins of the port controller
`timescale 1ns/1ps
module vdc_asserts (
   input logic        clk,
   input logic        nrst,
   input logic        rowStrobeN,
   input logic        colStrobeN,
   input logic [1:0]  byteWriteStrobeN,
   input logic        transferOutputEnableN,
   input logic        specialFunctionSelect,
   input logic [15:0] dataOut,
   input logic        dataOe
);
   // any byte write strobe active
   wire weLow = (byteWriteStrobeN != 2'h3);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_colInRow; $fell(colStrobeN) |-> !rowStrobeN; endproperty
   a_colInRow: assert property (p_colInRow)
      else $error("column strobe fell outside a row");
   property p_colHold; $fell(colStrobeN) |=> !colStrobeN; endproperty
   a_colHold: assert property (p_colHold)
      else $error("column phase too short");
   property p_weDrive; weLow |-> !dataOe && !rowStrobeN; endproperty
   a_weDrive: assert property (p_weDrive)
      else $error("write strobe without driven data");
   property p_weData; weLow && $past(weLow) |-> $stable(dataOut); endproperty
   a_weData: assert property (p_weData)
      else $error("write data moved under strobe");
   property p_oeOff; weLow |-> transferOutputEnableN; endproperty
   a_oeOff: assert property (p_oeOff)
      else $error("output enable low during write");
   property p_sfRow;
      $fell(rowStrobeN) |=> $stable(specialFunctionSelect);
   endproperty
   a_sfRow: assert property (p_sfRow)
      else $error("select moved at row fall");
   property p_sfCol;
      $fell(colStrobeN) |=> $stable(specialFunctionSelect);
   endproperty
   a_sfCol: assert property (p_sfCol)
      else $error("select moved at column fall");
   property p_maskPins; $fell(rowStrobeN) && weLow |-> !dataOe; endproperty
   a_maskPins: assert property (p_maskPins)
      else $error("bit mask not driven at row fall");
   property p_noFight; !transferOutputEnableN |-> dataOe; endproperty
   a_noFight: assert property (p_noFight)
      else $error("host drives pins during read");
endmodule
bind vdc_controller vdc_asserts chk_u (.clk(clk), .nrst(nrst),
   .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
   .byteWriteStrobeN(byteWriteStrobeN), .dataOe(dataOe),
   .transferOutputEnableN(transferOutputEnableN),
   .specialFunctionSelect(specialFunctionSelect), .dataOut(dataOut));

/* File: vdc_dram_model.sv */
// behavioural video dram port answering the controller strobes
`timescale 1ns/1ps
module vdc_dram_model #(
   parameter        EDO     = 0,
   parameter        BLK8    = 0,
   parameter        PERSIST = 0,
   parameter [15:0] COLOUR  = 16'h0000
) (
   input  wire        rowStrobeN,
   input  wire        colStrobeN,
   input  wire [1:0]  byteWriteStrobeN,
   input  wire        transferOutputEnableN,
   input  wire        specialFunctionSelect,
   input  wire [8:0]  addressIn,
   input  wire [15:0] dataOut,
   input  wire        dataOe,
   output wire [15:0] dataIn
);
   logic [15:0] mem [int];
   reg   [8:0]  row, col;
   reg          sfRow, blk, ldm;
   reg          drv = 1'h0;
   reg          weWas = 1'h0;
   reg   [15:0] bitMsk, wMask = 16'h0, rdVal = 16'h0;
   integer      c;
   wire         weLow = (byteWriteStrobeN != 2'h3);
   // released pins show the inverse of the last word
   assign dataIn = (drv && !transferOutputEnableN) ? rdVal : ~rdVal;
   // merge a word under bit mask and byte strobes
   task put(input [17:0] k, input [15:0] v);
      reg [15:0] m;
      begin
         m = bitMsk & {{8{!byteWriteStrobeN[1]}}, {8{!byteWriteStrobeN[0]}}};
         mem[k] = ((mem.exists(k) ? mem[k] : 16'h0) & ~m) | (v & m);
      end
   endtask
   // store what the pins carry at the later fall
   task commit;
      begin
         if (ldm) wMask = dataOut;
         else if (blk) begin
            for (c = 0; c < (BLK8 ? 8 : 4); c = c + 1)
               if (dataOut[c]) put({row, BLK8 ? {col[8:3], c[2:0]} :
                  {col[8:2], c[1:0]}}, COLOUR);
         end else put({row, col}, dataOut);
      end
   endtask
   // row open: latch row, mode and bit mask
   always @(negedge rowStrobeN) begin
      row = addressIn;
      sfRow = specialFunctionSelect;
      bitMsk = !weLow ? 16'hFFFF : PERSIST ? wMask : dataOut;
   end
   // column fall: read, or write if strobe already low
   always @(negedge colStrobeN) begin
      col = addressIn;
      blk = specialFunctionSelect;
      ldm = sfRow && !specialFunctionSelect;
      rdVal = mem.exists({row, col}) ? mem[{row, col}] : 16'h0;
      drv = !weLow;
      if (weLow) commit;
   end
   // first write strobe fall inside a column cycle
   always @(byteWriteStrobeN) begin
      if (weLow && !weWas && !colStrobeN) commit;
      weWas = weLow;
   end
   // page parts release at column rise, edo parts once both high
   always @(posedge colStrobeN or posedge rowStrobeN)
      if (colStrobeN && (!EDO || rowStrobeN)) drv = 1'h0;
endmodule

/* File: vdc_tb_top.sv */
// self-checking bench for the video dram port controller
`timescale 1ns/1ps
`include "vdc_defs.vh"
module tb_top;
   localparam [15:0] COLOUR = 16'h5A3C;
   reg         clk = 1'h0, nrst = 1'h0;
   reg  [3:0]  awaddr = 4'h0, araddr = 4'h0;
   reg  [31:0] wdata = 32'h0, d;
   reg         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   reg         arvalid = 1'h0, rready = 1'h0;
   wire        awready, wready, bvalid, arready, rvalid, dataOe;
   wire        rowStrobeN, colStrobeN, xOeN, selFn;
   wire [1:0]  bresp, rresp, byteWriteStrobeN;
   wire [31:0] rdata;
   wire [8:0]  addressIn;
   wire [15:0] dataOut, dataIn;
   integer     errorCnt = 0, comparisons = 0, cycles = 0;
   integer     seed = 32'h5082, i;
   logic [15:0] refMem [int];
   reg  [8:0]  row, col;
   reg  [15:0] dat, msk;
   reg  [1:0]  r, be;
   vdc_controller dut_u (.clk(clk), .nrst(nrst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
      .byteWriteStrobeN(byteWriteStrobeN), .transferOutputEnableN(xOeN),
      .specialFunctionSelect(selFn), .addressIn(addressIn),
      .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn));
   vdc_dram_model #(.COLOUR(COLOUR)) mdl_u (.rowStrobeN(rowStrobeN),
      .colStrobeN(colStrobeN), .byteWriteStrobeN(byteWriteStrobeN),
      .transferOutputEnableN(xOeN), .specialFunctionSelect(selFn),
      .addressIn(addressIn), .dataOut(dataOut), .dataOe(dataOe),
      .dataIn(dataIn));
   always #20 clk = ~clk;
   task tallyAndFinish;
      begin
         $display("errors %0d comparisons %0d", errorCnt, comparisons);
         if (errorCnt == 0 && comparisons > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   // hang guard
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         errorCnt = errorCnt + 1;
         tallyAndFinish;
      end
   end
   task chk(input [15:0] g, input [15:0] e);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            errorCnt = errorCnt + 1;
            $display("Error %0t: got %h want %h", $time, g, e);
         end
      end
   endtask
   // axi write: address and data offered together
   task axiWr(input [3:0] a, input [31:0] v);
      reg awPend, wPend;
      begin
         @(posedge clk);
         awaddr <= a;
         wdata <= v;
         awvalid <= 1'h1;
         wvalid <= 1'h1;
         bready <= 1'h1;
         awPend = 1'h1;
         wPend = 1'h1;
         // each channel released at the edge that takes it
         while (awPend || wPend) begin
            @(posedge clk);
            if (awPend && awready) begin
               awPend = 1'h0;
               awvalid <= 1'h0;
            end
            if (wPend && wready) begin
               wPend = 1'h0;
               wvalid <= 1'h0;
            end
         end
         while (!bvalid) @(posedge clk);
         chk(16'(bresp), 16'h0);
         bready <= 1'h0;
      end
   endtask
   task axiRd(input [3:0] a);
      begin
         @(posedge clk);
         araddr <= a;
         arvalid <= 1'h1;
         rready <= 1'h1;
         @(posedge clk);
         while (!arready) @(posedge clk);
         arvalid <= 1'h0;
         while (!rvalid) @(posedge clk);
         d = rdata;
         r = rresp;
         rready <= 1'h0;
      end
   endtask
   function [31:0] cw(input [1:0] op, input m, input b, input kp,
                      input [1:0] e, input [15:0] mk);
      cw = {mk, 7'h00, e, 1'h0, kp, b, m, op, 1'h1};
   endfunction
   // set address and data, start, wait until idle
   task runOp(input [31:0] c, input [8:0] ro, input [8:0] co,
              input [15:0] v);
      begin
         axiWr(`VDC_OFS_ADDR, {6'h00, ro, 8'h00, co});
         axiWr(`VDC_OFS_DATA, {16'h0000, v});
         axiWr(`VDC_OFS_CTRL, c);
         d = 32'h1;
         while (d[0]) axiRd(`VDC_OFS_STAT);
      end
   endtask
   function [15:0] refRd(input [8:0] ro, input [8:0] co);
      refRd = refMem.exists({ro, co}) ? refMem[{ro, co}] : 16'h0;
   endfunction
   task refWr(input [8:0] ro, input [8:0] co, input [15:0] v, m);
      refMem[{ro, co}] = (refRd(ro, co) & ~m) | (v & m);
   endtask
   // read a word back and compare with the reference
   task rdChk(input [8:0] ro, input [8:0] co);
      begin
         runOp(cw(`VDC_OP_READ, 1'h0, 1'h0, 1'h0, 2'h3, 16'h0), ro, co, 0);
         chk(d[31:16], refRd(ro, co));
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'h1;
      axiRd(4'h2);
      chk(16'(r), 16'(`VDC_RESP_SLVERR));
      for (i = 0; i < 8; i = i + 1) begin
         row = $random(seed);
         col = $random(seed);
         dat = $random(seed);
         msk = (i % 4 == 2) ? $random(seed) : 16'hFFFF;
         be = (i == 2) ? 2'h1 : (i == 4) ? 2'h2 : 2'h3;
         runOp(cw(`VDC_OP_WRITE, msk != 16'hFFFF, 1'h0, 1'h1, be, msk),
               row, col, dat);
         refWr(row, col, dat, {{8{be[1]}}, {8{be[0]}}} & msk);
         runOp(cw(i[0] ? `VDC_OP_RMW : `VDC_OP_READ, 1'h0, 1'h0, 1'h0,
               2'h3, 16'h0), row, col, ~dat);
         chk(d[31:16], refRd(row, col));
         if (i[0]) refWr(row, col, ~dat, 16'hFFFF);
         rdChk(row, col);
      end
      runOp(cw(`VDC_OP_WRITE, 1'h0, 1'h1, 1'h0, 2'h3, 16'hFFFF),
            row, col, dat);
      for (i = 0; i < 4; i = i + 1) begin
         if (dat[i]) refWr(row, {col[8:2], i[1:0]}, COLOUR, 16'hFFFF);
         rdChk(row, {col[8:2], i[1:0]});
      end
      runOp(cw(`VDC_OP_LDMASK, 1'h0, 1'h0, 1'h0, 2'h3, 16'h0),
            row, col, dat);
      chk(mdl_u.wMask, dat);
      tallyAndFinish;
   end
endmodule
